/* pkg/clk_switch_pkg.sv */
// Package: offsets, field positions, reset values and types of the CPU clock switch
package clk_switch_pkg;

    // ********************************
    // Register byte offsets
    // ********************************
    localparam logic [7:0] OFS_OSC_MODE  = 8'h00;
    localparam logic [7:0] OFS_PROC_CTRL = 8'h04;
    localparam logic [7:0] OFS_MAIN_MODE = 8'h08;
    localparam logic [7:0] OFS_INT_OSC   = 8'h0C;

    // ********************************
    // Field positions
    // ********************************
    localparam int BIT_SUB_OSC_EN     = 4;
    localparam int BIT_CPU_SUB_SEL    = 4;
    localparam int BIT_CPU_ON_SUB     = 5;
    localparam int BIT_DIV_LSB        = 0;
    localparam int BIT_MAIN_SRC_SEL   = 0;
    localparam int BIT_MAIN_SRC_STAT  = 1;
    localparam int BIT_INT_OSC_STOP   = 0;
    localparam int BIT_INT_OSC_STABLE = 7;

    // ********************************
    // Reset values and limits
    // ********************************
    localparam logic [2:0] DIV_RESET   = 3'h0;
    localparam logic [2:0] DIV_MAX     = 3'h4;
    localparam logic       SUB_EN_RST  = 1'h0;
    localparam logic       CPU_SUB_SEL_RST  = 1'h0;
    localparam logic       MAIN_SEL_RST     = 1'h0;
    localparam logic       INT_STOP_RST     = 1'h0;
    localparam logic [4:0] SUB_EDGES   = 5'h01;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        SRC_INT = 2'b00,
        SRC_HS  = 2'b01,
        SRC_SUB = 2'b10
    } src_e;

    typedef enum logic {
        SW_RUN  = 1'b0,
        SW_PARK = 1'b1
    } sw_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic        write;
        logic [31:0] wdata;
    } apb_req_s;

endpackage : clk_switch_pkg

/* hdl/cpu_clock_source_switch.sv */
// Design: CPU clock source switch with subsystem oscillator control over APB
//
// Contract
// - Enable bit at 1 turns subsystem pins from port use to oscillation.
// - Subsystem select bit at 1 routes subsystem clock to the CPU.
// - Divider codes 0 to 4 all give half subsystem frequency; others forbidden.
// - Two flags report source: 00 internal, 01 high speed, 1x subsystem.
// - Clearing the enable bit stops the subsystem oscillation.
// - Stop mode does not halt the subsystem oscillator.
// - Stable at bit 7, stop at bit 0, enable and select at 4, main at 0.
module cpu_clock_source_switch (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_int_osc_clk,
    input  wire logic        i_hs_clk,
    input  wire logic        i_sub_clk,
    input  wire logic        i_int_osc_ready,
    input  wire logic        i_stop_mode,
    output logic             o_cpu_clk,
    output logic             o_sub_osc_mode,
    output logic             o_sub_osc_run,
    output logic             o_int_osc_run
);

    // ********************************
    // Reset release
    // ********************************
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [3:0] pin_in;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [2:0] lvl_prev_r;
    logic [2:0] rise;

    assign pin_in = {i_int_osc_ready, i_sub_clk, i_hs_clk, i_int_osc_clk};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge i_clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_r[gi] <= 1'h0;
                    sync2_r[gi] <= 1'h0;
                end else begin
                    sync1_r[gi] <= pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_prev_r <= 3'h0;
        end else begin
            lvl_prev_r <= sync2_r[2:0];
        end
    end
    assign rise = sync2_r[2:0] & ~lvl_prev_r;

    // ********************************
    // APB slave and control registers
    // ********************************
    clk_switch_pkg::apb_req_s req;
    logic        sub_en_r,  sub_en_nxt;
    logic        cpu_sub_sel_r, cpu_sub_sel_nxt;
    logic        main_sel_r, main_sel_nxt;
    logic        int_stop_r, int_stop_nxt;
    logic [2:0]  div_r,     div_nxt;
    logic        pready_r,  pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r,  prdata_nxt;
    logic        wr_en;
    logic        stable;
    clk_switch_pkg::src_e cur_src_r, cur_src_nxt;

    assign req    = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign wr_en  = psel & penable & pready_r & req.write & ~pslverr_r;
    assign stable = sync2_r[3] & ~int_stop_r;

    always_comb begin
        sub_en_nxt  = sub_en_r;
        cpu_sub_sel_nxt = cpu_sub_sel_r;
        main_sel_nxt    = main_sel_r;
        int_stop_nxt    = int_stop_r;
        div_nxt     = div_r;
        pready_nxt  = psel & penable & ~pready_r;
        pslverr_nxt = 1'h0;
        prdata_nxt  = prdata_r;
        if (psel && penable && !pready_r) begin
            prdata_nxt = 32'h0000_0000;
            unique case (req.addr)
                clk_switch_pkg::OFS_OSC_MODE: begin
                    prdata_nxt[clk_switch_pkg::BIT_SUB_OSC_EN] = sub_en_r;
                end
                clk_switch_pkg::OFS_PROC_CTRL: begin
                    prdata_nxt[clk_switch_pkg::BIT_DIV_LSB +: 3]  = div_r;
                    prdata_nxt[clk_switch_pkg::BIT_CPU_SUB_SEL]   = cpu_sub_sel_r;
                    prdata_nxt[clk_switch_pkg::BIT_CPU_ON_SUB]    =
                        (cur_src_r == clk_switch_pkg::SRC_SUB);
                end
                clk_switch_pkg::OFS_MAIN_MODE: begin
                    prdata_nxt[clk_switch_pkg::BIT_MAIN_SRC_SEL]  = main_sel_r;
                    prdata_nxt[clk_switch_pkg::BIT_MAIN_SRC_STAT] =
                        (cur_src_r == clk_switch_pkg::SRC_HS);
                end
                clk_switch_pkg::OFS_INT_OSC: begin
                    prdata_nxt[clk_switch_pkg::BIT_INT_OSC_STOP]   = int_stop_r;
                    prdata_nxt[clk_switch_pkg::BIT_INT_OSC_STABLE] = stable;
                end
                default: begin
                    pslverr_nxt = 1'h1;
                end
            endcase
        end else if (psel && penable) begin
            pslverr_nxt = pslverr_r;
        end
        if (wr_en) begin
            unique case (req.addr)
                clk_switch_pkg::OFS_OSC_MODE: begin
                    sub_en_nxt = req.wdata[clk_switch_pkg::BIT_SUB_OSC_EN];
                end
                clk_switch_pkg::OFS_PROC_CTRL: begin
                    div_nxt = req.wdata[clk_switch_pkg::BIT_DIV_LSB +: 3];
                    cpu_sub_sel_nxt = req.wdata[clk_switch_pkg::BIT_CPU_SUB_SEL];
                end
                clk_switch_pkg::OFS_MAIN_MODE: begin
                    main_sel_nxt = req.wdata[clk_switch_pkg::BIT_MAIN_SRC_SEL];
                end
                clk_switch_pkg::OFS_INT_OSC: begin
                    int_stop_nxt = req.wdata[clk_switch_pkg::BIT_INT_OSC_STOP];
                end
                default: begin
                    sub_en_nxt = sub_en_r;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sub_en_r  <= clk_switch_pkg::SUB_EN_RST;
            cpu_sub_sel_r <= clk_switch_pkg::CPU_SUB_SEL_RST;
            main_sel_r    <= clk_switch_pkg::MAIN_SEL_RST;
            int_stop_r    <= clk_switch_pkg::INT_STOP_RST;
            div_r     <= clk_switch_pkg::DIV_RESET;
            pready_r  <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            sub_en_r  <= sub_en_nxt;
            cpu_sub_sel_r <= cpu_sub_sel_nxt;
            main_sel_r    <= main_sel_nxt;
            int_stop_r    <= int_stop_nxt;
            div_r     <= div_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r  <= prdata_nxt;
        end
    end

    // ********************************
    // Glitch-free source switch and divider
    // ********************************
    clk_switch_pkg::src_e      req_src;
    clk_switch_pkg::sw_state_e state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [4:0] limit;
    logic       cpu_clk_r, cpu_clk_nxt;
    logic       src_rise;

    always_comb begin
        if (cpu_sub_sel_r) begin
            req_src = clk_switch_pkg::SRC_SUB;
        end else if (main_sel_r) begin
            req_src = clk_switch_pkg::SRC_HS;
        end else begin
            req_src = clk_switch_pkg::SRC_INT;
        end
    end

    always_comb begin
        unique case (cur_src_r)
            clk_switch_pkg::SRC_SUB: begin
                src_rise = rise[2];
                limit    = clk_switch_pkg::SUB_EDGES;
            end
            clk_switch_pkg::SRC_HS: begin
                src_rise = rise[1];
                limit    = 5'h01 << ((div_r > clk_switch_pkg::DIV_MAX) ? 3'h4 : div_r);
            end
            default: begin
                src_rise = rise[0];
                limit    = 5'h01 << ((div_r > clk_switch_pkg::DIV_MAX) ? 3'h4 : div_r);
            end
        endcase
    end

    always_comb begin
        state_nxt   = state_r;
        cur_src_nxt = cur_src_r;
        cnt_nxt     = cnt_r;
        cpu_clk_nxt = cpu_clk_r;
        if (src_rise) begin
            if (cnt_r + 5'h01 >= limit) begin
                cnt_nxt     = 5'h00;
                cpu_clk_nxt = ~cpu_clk_r;
            end else begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end
        unique case (state_r)
            clk_switch_pkg::SW_RUN: begin
                if (req_src != cur_src_r) begin
                    state_nxt = clk_switch_pkg::SW_PARK;
                end
            end
            clk_switch_pkg::SW_PARK: begin
                if (!cpu_clk_r) begin
                    cur_src_nxt = req_src;
                    cnt_nxt     = 5'h00;
                    cpu_clk_nxt = 1'h0;
                    state_nxt   = clk_switch_pkg::SW_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= clk_switch_pkg::SW_RUN;
            cur_src_r <= clk_switch_pkg::SRC_INT;
            cnt_r     <= 5'h00;
            cpu_clk_r <= 1'h0;
        end else begin
            state_r   <= state_nxt;
            cur_src_r <= cur_src_nxt;
            cnt_r     <= cnt_nxt;
            cpu_clk_r <= cpu_clk_nxt;
        end
    end

    // ********************************
    // Oscillator controls
    // ********************************
    logic osc_mode_r;
    logic sub_run_r;
    logic int_run_r;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_mode_r <= 1'h0;
            sub_run_r  <= 1'h0;
            int_run_r  <= 1'h0;
        end else begin
            osc_mode_r <= sub_en_nxt;
            sub_run_r  <= sub_en_nxt;
            int_run_r  <= ~int_stop_nxt & ~i_stop_mode;
        end
    end

    assign o_prdata       = prdata_r;
    assign o_pready       = pready_r;
    assign o_pslverr      = pslverr_r;
    assign o_cpu_clk      = cpu_clk_r;
    assign o_sub_osc_mode = osc_mode_r;
    assign o_sub_osc_run  = sub_run_r;
    assign o_int_osc_run  = int_run_r;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    pin_mode_follow_a: assert property (wr_en && req.addr == clk_switch_pkg::OFS_OSC_MODE
        |=> o_sub_osc_mode == $past(pwdata[4])) else $error("Pin mode not updated");
    sub_route_a: assert property ($changed(cur_src_r) && cur_src_r == clk_switch_pkg::SRC_SUB
        |-> cpu_sub_sel_r) else $error("Subsystem routed without select");
    sub_half_a: assert property (cur_src_r == clk_switch_pkg::SRC_SUB && state_r ==
        clk_switch_pkg::SW_RUN && rise[2] |=> $changed(o_cpu_clk))
        else $error("Subsystem clock not halved");
    flag_report_a: assert property (o_pready && !pwrite && paddr == clk_switch_pkg::OFS_PROC_CTRL
        && !o_pslverr |-> o_prdata[5] == $past(cur_src_r == clk_switch_pkg::SRC_SUB))
        else $error("Subsystem flag wrong");
    osc_stop_a: assert property (wr_en && req.addr == clk_switch_pkg::OFS_OSC_MODE && !pwdata[4]
        |=> !o_sub_osc_run) else $error("Subsystem oscillator not stopped");
    stop_mode_keep_a: assert property (i_stop_mode && o_sub_osc_run && !wr_en
        |=> o_sub_osc_run [*1]) else $error("Stop mode halted subsystem");
    stable_bit_a: assert property (o_pready && !pwrite && paddr == clk_switch_pkg::OFS_INT_OSC
        && !o_pslverr |-> o_prdata[7] == $past(stable) && o_prdata[0] == $past(int_stop_r))
        else $error("Internal oscillator fields misplaced");
    switch_low_a: assert property ($changed(cur_src_r) |-> !o_cpu_clk && $past(!o_cpu_clk))
        else $error("Source switched while clock high");

    switch_to_sub_c: cover property ($changed(cur_src_r) && cur_src_r == clk_switch_pkg::SRC_SUB);
    switch_to_hs_c: cover property ($changed(cur_src_r) && cur_src_r == clk_switch_pkg::SRC_HS);
    back_to_int_c: cover property ($changed(cur_src_r) && cur_src_r == clk_switch_pkg::SRC_INT);
    bad_addr_c: cover property (o_pready && o_pslverr);

endmodule // cpu_clock_source_switch

/* verif/sub_resonator_model.sv */
// Crystal resonator model on the subsystem oscillator pins
module sub_resonator_model #(
    parameter int HALF_NS  = 400,
    parameter int START_NS = 1000
) (
    input  wire logic i_osc_mode,
    input  wire logic i_osc_run,
    output logic      o_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************
    // Oscillation, still when stopped
    // ************************************
    always begin
        if (i_osc_mode && i_osc_run) begin
            #(HALF_NS);
            o_clk = (i_osc_mode && i_osc_run) ? ~o_clk : 1'b0;
        end else begin
            o_clk = 1'b0;
            @(posedge i_osc_run or posedge i_osc_mode);
            #(START_NS);
        end
    end
endmodule // sub_resonator_model

/* verif/testbench.sv */
// Testbench for the CPU clock source switch
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         INT_CYC = 8;
    localparam int         HS_CYC  = 6;
    localparam int         SUB_CYC = 16;
    localparam logic [7:0] A_OSC   = clk_switch_pkg::OFS_OSC_MODE;
    localparam logic [7:0] A_PROC  = clk_switch_pkg::OFS_PROC_CTRL;
    localparam logic [7:0] A_MAIN  = clk_switch_pkg::OFS_MAIN_MODE;
    localparam logic [7:0] A_INT   = clk_switch_pkg::OFS_INT_OSC;

    logic        i_clk_sys = 1'b0;
    logic        i_rst_b   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        int_clk   = 1'b0;
    logic        hs_clk    = 1'b0;
    logic        sub_clk;
    logic        int_rdy   = 1'b1;
    logic        stop_mode = 1'b0;
    logic        o_cpu_clk;
    logic        o_sub_osc_mode;
    logic        o_sub_osc_run;
    logic        o_int_osc_run;
    int          n_mismatch = 0;
    int          checks     = 0;

    always #25 i_clk_sys = ~i_clk_sys;
    initial begin #13; forever #200 int_clk = ~int_clk; end
    initial begin #31; forever #150 hs_clk = ~hs_clk; end

    cpu_clock_source_switch i_dut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_int_osc_clk(int_clk),
        .i_hs_clk(hs_clk), .i_sub_clk(sub_clk), .i_int_osc_ready(int_rdy),
        .i_stop_mode(stop_mode), .o_cpu_clk(o_cpu_clk), .o_sub_osc_mode(o_sub_osc_mode),
        .o_sub_osc_run(o_sub_osc_run), .o_int_osc_run(o_int_osc_run));

    sub_resonator_model i_xtal (
        .i_osc_mode(o_sub_osc_mode), .i_osc_run(o_sub_osc_run), .o_clk(sub_clk));

    // ************************************
    // Tasks
    // ************************************
    task automatic report_and_stop;
        $display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge i_clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) n_mismatch++;
        rd = o_prdata;
        err = o_pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        logic        err;
        int          k;
        k = 0;
        do begin
            apb(1'b0, a, 32'h0, rd, err);
            k++;
        end while ((rd & m) !== e && k < 40);
        chk(rd & m, e);
    endtask

    task automatic period_chk(input int exp);
        int   n;
        int   k;
        logic p;
        n = 0;
        k = 0;
        p = o_cpu_clk;
        while (k < 3 && n < 3000) begin
            @(posedge i_clk_sys);
            if (o_cpu_clk === 1'b1 && p === 1'b0) begin
                k++;
                if (k == 2) n = 0;
            end
            p = o_cpu_clk;
            n++;
        end
        chk(32'(n - 1), 32'(exp));
    endtask

    // ************************************
    // Tests
    // ************************************
    initial begin
        logic [31:0] rd;
        logic        err;
        repeat (8) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        chk({29'h0, o_sub_osc_mode, o_sub_osc_run, o_int_osc_run}, 32'h1);
        rd_chk(A_OSC, 32'h0);
        rd_chk(A_PROC, 32'h0);
        rd_chk(A_MAIN, 32'h0);
        rd_chk(A_INT, 32'h80);
        apb(1'b1, 8'h10, 32'hFFFF_FFFF, rd, err);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h10, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        rd_chk(A_OSC, 32'h0);
        int_rdy <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        rd_chk(A_INT, 32'h0);
        int_rdy <= 1'b1;
        wr(A_INT, 32'h1);
        chk({31'h0, o_int_osc_run}, 32'h0);
        rd_chk(A_INT, 32'h1);
        wr(A_INT, 32'h0);
        wait_reg(A_INT, 32'h80, 32'h80);
        period_chk(INT_CYC * 2);
        $display("test reset_and_regs done");

        wr(A_MAIN, 32'h1);
        wait_reg(A_MAIN, 32'h2, 32'h2);
        for (int c = 0; c < 5; c++) begin
            wr(A_PROC, 32'(c));
            period_chk(HS_CYC << (c + 1));
        end
        wr(A_PROC, 32'h7);
        period_chk(HS_CYC << 5);
        $display("test high_speed done");

        wr(A_OSC, 32'h10);
        chk({30'h0, o_sub_osc_mode, o_sub_osc_run}, 32'h3);
        repeat (60) @(posedge i_clk_sys);
        wr(A_PROC, 32'h14);
        wait_reg(A_PROC, 32'h20, 32'h20);
        for (int c = 0; c < 5; c++) begin
            wr(A_PROC, 32'h10 | 32'(c));
            period_chk(SUB_CYC * 2);
        end
        stop_mode <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        chk({30'h0, o_sub_osc_run, o_int_osc_run}, 32'h2);
        period_chk(SUB_CYC * 2);
        stop_mode <= 1'b0;
        $display("test subsystem done");

        wait_reg(A_INT, 32'h80, 32'h80);
        wr(A_MAIN, 32'h0);
        wr(A_PROC, 32'h0);
        wait_reg(A_PROC, 32'h20, 32'h0);
        rd_chk(A_MAIN, 32'h0);
        period_chk(INT_CYC * 2);
        wr(A_OSC, 32'h0);
        chk({30'h0, o_sub_osc_mode, o_sub_osc_run}, 32'h0);
        $display("test back_to_internal done");
        report_and_stop();
    end

    initial begin
        #2_000_000;
        n_mismatch++;
        report_and_stop();
    end
endmodule // testbench
